// >>> logic/scl_core.sv
// Operation
// - Toggle the zero-cross flag on each valid back-EMF crossing of centertap.
// - The zero-cross flag can be routed to the diagnostic output.
// - Commutate once a valid crossing has passed the adaptive delay, or on watchdog expiry.
// - On each flag change, run one delay timer down at twice rate; commutate once it falls below two.
// - The other delay timer accumulates meanwhile; the two alternate each half-period.
// - Delay accumulation pauses during blanking.
// - Blank from each new state until the watchdog reaches its low threshold.
// - The watchdog rate field sets blanking and watchdog length; higher is shorter.
// - Valid back-EMF after blanking clears the watchdog and disarms detection until the next commutation.
// - Without valid back-EMF by watchdog expiry, force commutation and repeat.
// - Count three flag transitions per pole for one mechanical revolution.
// - Toggle rev_a once per revolution; each rising rev_a starts the reference counter.
// - Reference interval lasts the sum of selected speed-field weights in clocks.
// - Rev_a falling before reference end gives overspeed; after gives underspeed.
// - Underspeed pulse enables charging, overspeed pulse enables discharging.
// - External speed control bit disables the frequency-lock loop.
// - Current limit follows the two-bit field, scaled by the gain.
// - Rev_a source bit selects the external sector input as rev_a.
// - Pole field: 00 eight, 01 four, 10 sixteen, 11 twelve poles.
// - Speed bits are active low, weights 16 up to 131072.
// - Diagnostic select: 00 rev_a, 01 thermal, 10 sync, 11 zero-cross flag.
// - Six states, start in state 1, reverse direction steps backwards.
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
`include "scl_params.svh"

module scl_core
	import scl_pkg::*;
#(
	parameter int CNT_W = 20,
	parameter int WD_W  = 16
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        bemf_above,
	input  wire logic        sector_in,
	input  wire logic        thermal_sd,
	output logic      [2:0]  phase_hi,
	output logic      [2:0]  phase_lo,
	output logic             diag_out,
	output logic             filt_charge,
	output logic             filt_discharge,
	output logic             fll_enable,
	output logic             gain_two,
	output logic      [1:0]  current_limit_sel
);

	generate
		if (CNT_W < 18 || WD_W < 16) begin : g_chk
			$error("scl_core: counter widths too narrow");
		end
	endgenerate

	// =====================================================================
	// Helpers
	// =====================================================================
	function automatic scl_state_t step(input scl_state_t s, input logic rev);
		case (s)
			SCL_S1:  step = rev ? SCL_S6 : SCL_S2;
			SCL_S2:  step = rev ? SCL_S1 : SCL_S3;
			SCL_S3:  step = rev ? SCL_S2 : SCL_S4;
			SCL_S4:  step = rev ? SCL_S3 : SCL_S5;
			SCL_S5:  step = rev ? SCL_S4 : SCL_S6;
			default: step = rev ? SCL_S5 : SCL_S1;
		endcase
	endfunction : step

	// Returns {high side, low side}; bit 0 is phase A, bit 2 is phase C.
	function automatic logic [5:0] drive(input scl_state_t s);
		case (s)
			SCL_S1:  drive = {3'b001, 3'b100};
			SCL_S2:  drive = {3'b001, 3'b010};
			SCL_S3:  drive = {3'b100, 3'b010};
			SCL_S4:  drive = {3'b100, 3'b001};
			SCL_S5:  drive = {3'b010, 3'b001};
			default: drive = {3'b010, 3'b100};
		endcase
	endfunction : drive

	// =====================================================================
	// Register bus
	// =====================================================================
	logic [31:0] cfg_r;
	logic        ack_r;
	logic [31:0] rdat_r;
	logic        req;
	logic [31:0] status;

	assign req = wb_cyc_i && wb_stb_i && !ack_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_r <= `SCL_CFG_RST;
		end else if (req && wb_we_i && wb_adr_i == `SCL_CFG_OFS) begin
			for (int i = 0; i < 4; i++) begin
				if (wb_sel_i[i]) begin
					cfg_r[i*8 +: 8] <= wb_dat_i[i*8 +: 8] & 8'(`SCL_CFG_MASK >> (i*8));
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdat_r <= 32'h0000_0000;
		end else if (req) begin
			if (wb_adr_i == `SCL_CFG_OFS) begin
				rdat_r <= cfg_r;
			end else if (wb_adr_i == `SCL_STAT_OFS) begin
				rdat_r <= status;
			end else begin
				rdat_r <= 32'h0000_0000;
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	logic       run, brake, rev, ext_spd, rev_a_src;
	logic [1:0] wd_rate_sel, pole_sel;
	assign run         = cfg_r[`SCL_B_RUN];
	assign brake       = cfg_r[`SCL_B_BRAKE];
	assign rev         = cfg_r[`SCL_B_DIR];
	assign ext_spd     = cfg_r[`SCL_B_EXT_SPD];
	assign rev_a_src    = cfg_r[`SCL_B_REV_A_SRC];
	assign wd_rate_sel = {cfg_r[`SCL_B_WDR_HI], cfg_r[`SCL_B_WDR_LO]};
	assign pole_sel    = {cfg_r[`SCL_B_POLE_HI], cfg_r[`SCL_B_POLE_LO]};

	// =====================================================================
	// Watchdog, blanking and crossing detection
	// =====================================================================
	scl_state_t           state_r;
	logic [WD_W-1:0]      wd_cnt_r;
	logic                 blank_r;
	logic                 armed_r;
	logic                 zc_r;
	logic                 detect;
	logic                 wd_expire;
	logic                 dly_done;
	logic                 commutate;
	logic [WD_W-1:0]      wd_step;

	assign wd_step   = WD_W'(wd_rate_sel) + WD_W'(1);
	assign detect    = run && armed_r && !blank_r &&
	                   (bemf_above == ((state_r[1] | state_r[3] | state_r[5]) ^ rev));
	assign wd_expire = armed_r && !detect && (wd_cnt_r >= `SCL_WD_TH - wd_step);
	assign commutate = run && (dly_done || wd_expire);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= SCL_S1;
		end else if (!run) begin
			state_r <= SCL_S1;
		end else if (commutate) begin
			state_r <= step(state_r, rev);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wd_cnt_r <= '0;
			blank_r  <= 1'b1;
			armed_r  <= 1'b1;
		end else if (!run || commutate) begin
			wd_cnt_r <= '0;
			blank_r  <= 1'b1;
			armed_r  <= 1'b1;
		end else if (detect) begin
			wd_cnt_r <= '0;
			armed_r  <= 1'b0;
		end else if (armed_r) begin
			wd_cnt_r <= wd_cnt_r + wd_step;
			if (wd_cnt_r + wd_step >= `SCL_BLANK_TH) begin
				blank_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			zc_r <= 1'b0;
		end else if (detect) begin
			zc_r <= !zc_r;
		end
	end

	// =====================================================================
	// Adaptive commutation delay
	// =====================================================================
	logic [CNT_W-1:0] dly_a_r, dly_b_r;
	logic             use_b_r;
	logic             dly_run_r;
	logic [CNT_W-1:0] dly_run_val;

	assign dly_run_val = use_b_r ? dly_a_r : dly_b_r;
	assign dly_done    = dly_run_r && (dly_run_val < CNT_W'(2));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dly_a_r   <= '0;
			dly_b_r   <= '0;
			use_b_r   <= 1'b0;
			dly_run_r <= 1'b0;
		end else if (!run) begin
			dly_a_r   <= '0;
			dly_b_r   <= '0;
			dly_run_r <= 1'b0;
		end else if (detect) begin
			use_b_r   <= !use_b_r;
			dly_run_r <= 1'b1;
			if (use_b_r) begin
				dly_a_r <= '0;
			end else begin
				dly_b_r <= '0;
			end
		end else begin
			if (dly_done || commutate) begin
				dly_run_r <= 1'b0;
			end
			if (use_b_r) begin
				if (!blank_r && dly_b_r != '1) begin
					dly_b_r <= dly_b_r + CNT_W'(1);
				end
				if (dly_run_r && !dly_done) begin
					dly_a_r <= dly_a_r - CNT_W'(2);
				end
			end else begin
				if (!blank_r && dly_a_r != '1) begin
					dly_a_r <= dly_a_r + CNT_W'(1);
				end
				if (dly_run_r && !dly_done) begin
					dly_b_r <= dly_b_r - CNT_W'(2);
				end
			end
		end
	end

	// =====================================================================
	// Rev_a and speed reference
	// =====================================================================
	logic [5:0]       pole_cnt_r;
	logic [5:0]       pole_lim;
	logic             rev_a_int_r;
	logic             rev_a_prev_r;
	logic             rev_a;
	logic [CNT_W-1:0] ref_cnt_r;
	logic             ref_run_r;
	logic [17:0]      ref_total;

	always_comb begin
		case (pole_sel)
			2'h0:    pole_lim = `SCL_ZC_P8;
			2'h1:    pole_lim = `SCL_ZC_P4;
			2'h2:    pole_lim = `SCL_ZC_P16;
			default: pole_lim = `SCL_ZC_P12;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pole_cnt_r <= '0;
			rev_a_int_r <= 1'b0;
		end else if (detect) begin
			if (pole_cnt_r >= pole_lim - 6'd1) begin
				pole_cnt_r <= '0;
				rev_a_int_r <= !rev_a_int_r;
			end else begin
				pole_cnt_r <= pole_cnt_r + 6'd1;
			end
		end
	end

	assign rev_a      = rev_a_src ? sector_in : rev_a_int_r;
	assign ref_total = {~cfg_r[`SCL_B_SPD_MSB:`SCL_B_SPD_LSB], 4'h0};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rev_a_prev_r <= 1'b0;
		end else begin
			rev_a_prev_r <= rev_a;
		end
	end

	// The interval restarts on every rising rev_a, so a missed fall simply rearms.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ref_cnt_r <= '0;
			ref_run_r <= 1'b0;
		end else if (rev_a && !rev_a_prev_r) begin
			ref_cnt_r <= CNT_W'(ref_total);
			ref_run_r <= (ref_total != 18'h0_0000);
		end else if (ref_run_r) begin
			ref_cnt_r <= ref_cnt_r - CNT_W'(1);
			if (ref_cnt_r <= CNT_W'(1)) begin
				ref_run_r <= 1'b0;
			end
		end
	end

	// =====================================================================
	// Outputs
	// =====================================================================
	logic       rev_a_fall;
	logic [5:0] drv;
	assign rev_a_fall = !rev_a && rev_a_prev_r;
	assign drv       = drive(state_r);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			filt_charge    <= 1'b0;
			filt_discharge <= 1'b0;
			fll_enable     <= 1'b0;
		end else begin
			fll_enable     <= !ext_spd;
			filt_discharge <= !ext_spd && rev_a_fall && ref_run_r;
			filt_charge    <= !ext_spd && rev_a_fall && !ref_run_r;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase_hi <= 3'h0;
			phase_lo <= 3'h0;
		end else if (!run) begin
			phase_hi <= 3'h0;
			phase_lo <= 3'h0;
		end else if (brake) begin
			phase_hi <= 3'h0;
			phase_lo <= 3'h7;
		end else begin
			phase_hi <= drv[5:3];
			phase_lo <= drv[2:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			diag_out <= 1'b0;
		end else begin
			case (scl_diag_t'({cfg_r[`SCL_B_DIAG_HI], cfg_r[`SCL_B_DIAG_LO]}))
				SCL_DIAG_REV_A:  diag_out <= rev_a;
				SCL_DIAG_THERM: diag_out <= thermal_sd;
				SCL_DIAG_SYNC:  diag_out <= ref_run_r;
				default:        diag_out <= zc_r;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gain_two          <= 1'b0;
			current_limit_sel <= 2'h0;
		end else begin
			gain_two          <= cfg_r[`SCL_B_GAIN];
			current_limit_sel <= {cfg_r[`SCL_B_ILIM_HI], cfg_r[`SCL_B_ILIM_LO]};
		end
	end

	assign status = {20'h0_0000, thermal_sd, ref_run_r, blank_r, rev_a, zc_r, 1'b0,
	                 state_r};

endmodule : scl_core

// >>> logic/scl_params.svh
`ifndef SCL_PARAMS_SVH
`define SCL_PARAMS_SVH

// Register byte offsets on the bus.
`define SCL_CFG_OFS      8'h00
`define SCL_STAT_OFS     8'h04
`define SCL_CFG_RST      32'h0000_0000
`define SCL_CFG_MASK     32'h1fff_ffff

// Configuration word bit positions.
`define SCL_B_RUN        0
`define SCL_B_BRAKE      2
`define SCL_B_ILIM_HI    3
`define SCL_B_ILIM_LO    4
`define SCL_B_SPD_LSB    5
`define SCL_B_SPD_MSB    18
`define SCL_B_REV_A_SRC   19
`define SCL_B_POLE_HI    20
`define SCL_B_POLE_LO    21
`define SCL_B_DIAG_HI    22
`define SCL_B_DIAG_LO    23
`define SCL_B_EXT_SPD    24
`define SCL_B_DIR        25
`define SCL_B_WDR_HI     26
`define SCL_B_WDR_LO     27
`define SCL_B_GAIN       28

// Speed weight of the lowest speed bit is 2**4 = 16.
`define SCL_SPD_SHIFT    4

// Watchdog thresholds in rate-0 steps; the step is the rate field plus one.
`define SCL_BLANK_TH     16'd256
`define SCL_WD_TH        16'd4096

// Pole-count transitions per revolution: poles times three.
`define SCL_ZC_P8        6'd24
`define SCL_ZC_P4        6'd12
`define SCL_ZC_P16       6'd48
`define SCL_ZC_P12       6'd36

`endif

// >>> logic/scl_pkg.sv
package scl_pkg;

	typedef enum logic [5:0] {
		SCL_S1 = 6'b000001,
		SCL_S2 = 6'b000010,
		SCL_S3 = 6'b000100,
		SCL_S4 = 6'b001000,
		SCL_S5 = 6'b010000,
		SCL_S6 = 6'b100000
	} scl_state_t;

	typedef enum logic [1:0] {
		SCL_DIAG_REV_A  = 2'h0,
		SCL_DIAG_THERM = 2'h1,
		SCL_DIAG_SYNC  = 2'h2,
		SCL_DIAG_ZC    = 2'h3
	} scl_diag_t;

endpackage : scl_pkg

// >>> sim/scl_core_asserts.sv
`timescale 1ns/100ps
// ========
// Port checks for the commutation core.
module scl_core_chk (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [2:0]  phase_hi,
	input wire logic [2:0]  phase_lo,
	input wire logic        filt_charge,
	input wire logic        filt_discharge,
	input wire logic        fll_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	AST_ACK_ONCE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	AST_UNMAPPED: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) >= 8'h08
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	AST_CFG_TOP: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h00
		|-> wb_dat_o[31:29] == 3'h0) else $error("unused config bits set");
	AST_NO_SHORT: assert property ((phase_hi & phase_lo) == 3'h0)
		else $error("phase driven high and low");
	AST_ONE_DRIVE: assert property ($onehot0(phase_hi) && $onehot0(phase_lo))
		else $error("more than one phase sourcing or sinking");
	AST_STATE_HOLD: assert property ($changed({phase_hi, phase_lo}) && phase_hi != 3'h0
		&& $past(phase_hi) != 3'h0 |=> (phase_hi == 3'h0 || $stable({phase_hi, phase_lo}))[*8])
		else $error("state left during blanking");
	AST_ERR_PULSE: assert property (filt_charge || filt_discharge
		|=> !filt_charge && !filt_discharge) else $error("error pulse too long");
	AST_ERR_EXCL: assert property (!(filt_charge && filt_discharge))
		else $error("both error pulses");
	AST_FLL_MUTE: assert property (!fll_enable && !$past(fll_enable)
		|-> !filt_charge && !filt_discharge) else $error("pulse with loop disabled");
	cover property (filt_charge);
	cover property (filt_discharge);
	cover property ($changed(phase_lo) && phase_lo != 3'h0);
endmodule : scl_core_chk

bind scl_core scl_core_chk scl_core_chk_inst (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_dat_o, .wb_ack_o, .phase_hi, .phase_lo, .filt_charge, .filt_discharge,
	.fll_enable);

// >>> sim/scl_motor_model.sv
`timescale 1ns/100ps
// ========
// Motor behind the bridges: the floating phase crosses centertap lag cycles
// after each commutation, never while stalled.
module scl_motor_model (
	input  wire logic       clk,
	input  wire logic [2:0] phase_hi,
	input  wire logic [2:0] phase_lo,
	input  wire logic       rev,
	input  wire logic       stall,
	input  wire logic [7:0] lag,
	output logic            bemf_above
);
	logic [5:0]  prev_r = 6'h0;
	logic [15:0] age_r = 16'h0;
	logic        rise;
	// The crossing direction follows the spin direction.
	assign rise = rev ? (phase_lo == {phase_hi[0], phase_hi[2:1]})
		: (phase_lo == {phase_hi[1:0], phase_hi[2]});
	always_ff @(posedge clk) begin
		prev_r <= {phase_hi, phase_lo};
		if ({phase_hi, phase_lo} != prev_r)
			age_r <= 16'h0;
		else if (age_r != 16'hffff)
			age_r <= age_r + 16'h1;
	end
	assign bemf_above = (age_r >= 16'(lag) && !stall) ? rise : !rise;
endmodule : scl_motor_model

// >>> sim/scl_core_tb_top.sv
`timescale 1ns/100ps
`include "scl_params.svh"
// ========
// Register, commutation and speed-loop scenarios.
module scl_core_tb_top
	import scl_pkg::*;
;
	logic        clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, t;
	logic [7:0]  wb_adr_i, lag;
	logic [31:0] wb_dat_i, wb_dat_o, x;
	logic [3:0]  wb_sel_i;
	logic [2:0]  phase_hi, phase_lo;
	logic [1:0]  current_limit_sel, g;
	logic [5:0]  p;
	logic        bemf_above, sector_in, thermal_sd, diag_out, filt_charge, filt_discharge;
	logic        fll_enable, gain_two, rev, stall;
	int          miscompares, num_checks, cycles, n;
	logic [5:0]  seq [6] = '{6'h0c, 6'h0a, 6'h22, 6'h21, 6'h11, 6'h14};
	int          pz [4] = '{24, 12, 48, 36};

	scl_core scl_core_inst (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
		.wb_sel_i, .wb_dat_o, .wb_ack_o, .bemf_above, .sector_in, .thermal_sd, .phase_hi,
		.phase_lo, .diag_out, .filt_charge, .filt_discharge, .fll_enable, .gain_two,
		.current_limit_sel);
	scl_motor_model scl_motor_model_inst (.clk, .phase_hi, .phase_lo, .rev, .stall, .lag,
		.bemf_above);

	task automatic end_sim();
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		num_checks++;
		if (got !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, e);
		end
	endtask : chk

	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		x = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : xfer

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(x, e);
	endtask : rdchk

	task automatic next_state(input logic [5:0] e);
		p = {phase_hi, phase_lo};
		n = 0;
		while ({phase_hi, phase_lo} === p) begin
			@(posedge clk);
			n++;
		end
		chk(32'({phase_hi, phase_lo}), 32'(e));
	endtask : next_state

	// The idle gap lets the previous sector's reference run out before the next rising edge.
	task automatic sector(input int hi_len, input logic [1:0] e);
		g = 2'b00;
		repeat (300) @(posedge clk);
		sector_in <= 1'b1;
		repeat (hi_len) @(posedge clk);
		sector_in <= 1'b0;
		repeat (40) begin
			@(posedge clk);
			g = g | {filt_charge, filt_discharge};
		end
		chk(32'(g), 32'(e));
	endtask : sector

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			miscompares++;
			end_sim();
		end
	end

	initial begin
		{nrst, wb_cyc_i, wb_stb_i, wb_we_i, sector_in, thermal_sd, rev, stall} = 8'h0;
		wb_adr_i = 8'h0;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hf;
		lag = 8'h0a;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rdchk(`SCL_CFG_OFS, 32'h0);
		rdchk(`SCL_STAT_OFS, 32'h0000_0201);
		chk(32'({fll_enable, phase_hi, phase_lo}), 32'h40);
		xfer(1'b1, `SCL_CFG_OFS, 32'h1100_0008);
		xfer(1'b1, 8'h10, 32'hffff_ffff);
		rdchk(8'h10, 32'h0);
		rdchk(`SCL_CFG_OFS, 32'h1100_0008);
		chk(32'({gain_two, current_limit_sel, fll_enable}), 32'hc);
		thermal_sd <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, `SCL_CFG_OFS, (32'(i[0]) << 23) | (32'(i[1]) << 22));
			@(posedge clk);
			chk(32'(diag_out), 32'(i == 1));
		end
		xfer(1'b1, `SCL_CFG_OFS, 32'h0080_0000);
		thermal_sd <= 1'b0;
		repeat (4) @(posedge clk);
		chk(32'(diag_out), 32'h0);
		xfer(1'b1, `SCL_CFG_OFS, 32'h0ce0_0001);
		@(posedge clk);
		chk(32'({phase_hi, phase_lo}), 32'h0c);
		t = 1'b0;
		for (int k = 1; k <= 6; k++) begin
			next_state(seq[k % 6]);
			t = ~t;
			chk(32'(diag_out), 32'(t));
		end
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, `SCL_CFG_OFS, 32'h0c00_0001 | (32'(i[1]) << 20) | (32'(i[0]) << 21));
			t = diag_out;
			while (diag_out === t) @(posedge clk);
			t = diag_out;
			n = 0;
			p = {phase_hi, phase_lo};
			while (diag_out === t) begin
				@(posedge clk);
				if ({phase_hi, phase_lo} !== p)
					n++;
				p = {phase_hi, phase_lo};
			end
			chk(32'(n), 32'(pz[i]));
		end
		stall <= 1'b1;
		rev <= 1'b1;
		xfer(1'b1, `SCL_CFG_OFS, 32'h0);
		xfer(1'b1, `SCL_CFG_OFS, 32'h0e00_0001);
		// Let state 1 reach the pins so that the first wait starts from it.
		@(posedge clk);
		for (int k = 5; k >= 3; k--) begin
			next_state(seq[k]);
			chk(32'(n >= 1000 && n <= 1050), 32'h1);
		end
		stall <= 1'b0;
		next_state(seq[2]);
		next_state(seq[1]);
		chk(32'(n < 1000), 32'h1);
		// A late crossing makes the delay timers matter: detection comes lag plus three
		// clocks into each state, and at rate 3 blanking lasts a quarter of the threshold.
		lag <= 8'd200;
		for (int k = 0; k < 10; k++) begin
			next_state(seq[(12 - k) % 6]);
		end
		chk(32'(2 * (n - int'(lag) - 3) <= n - int'(`SCL_BLANK_TH) / 4 + 4 &&
			2 * (n - int'(lag) - 3) >= n - int'(`SCL_BLANK_TH) / 4 - 4), 32'h1);
		chk(32'(2 * (n - int'(lag) - 3) < n), 32'h1);
		xfer(1'b1, `SCL_CFG_OFS, 32'h000f_fdc1);
		sector(240, 2'b01);
		sector(304, 2'b10);
		xfer(1'b1, `SCL_CFG_OFS, 32'h010f_fdc1);
		sector(240, 2'b00);
		end_sim();
	end
endmodule : scl_core_tb_top
